// [core/scp_pin_sync.sv]
`timescale 1ns/1ps
module scp_pin_sync (
    input  wire logic sys_clk,
    input  wire logic reset,
    input  wire logic sclk,
    input  wire logic chip_select_n,
    input  wire logic sdio_in,
    input  wire logic port_abort,
    scp_pins_if.sync  pins
);

    typedef struct packed {
        logic [3:0] meta;
        logic [3:0] stab;
        logic       sclk_old;
    } scp_sync_s;

    scp_sync_s s_q;
    scp_sync_s s_d;

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        s_d          = s_q;
        s_d.meta     = {port_abort, sdio_in, chip_select_n, sclk};
        s_d.stab     = s_q.meta;
        s_d.sclk_old = s_q.stab[0];
    end

    // Chip select idles high so a reset cannot fake a selection
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            s_q <= '{meta: 4'h2, stab: 4'h2, sclk_old: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Edges found on the second stage only
    assign pins.sclk_rise = s_q.stab[0] & ~s_q.sclk_old;
    assign pins.sclk_fall = ~s_q.stab[0] & s_q.sclk_old;
    assign pins.sel_n     = s_q.stab[1];
    assign pins.data_in   = s_q.stab[2];
    assign pins.abort     = s_q.stab[3];

endmodule

// [core/scp_pins_if.sv]
`timescale 1ns/1ps
interface scp_pins_if;
    logic sclk_rise;
    logic sclk_fall;
    logic sel_n;
    logic data_in;
    logic abort;

    modport sync (output sclk_rise, output sclk_fall, output sel_n,
                  output data_in, output abort);
    modport core (input sclk_rise, input sclk_fall, input sel_n,
                  input data_in, input abort);
endinterface

// [core/scp_pkg.sv]
package scp_pkg;

    // Serial address and field positions
    localparam logic [4:0] CTRL_ADDR     = 5'h00;
    localparam logic [4:0] AMPL_ADDR     = 5'h02;
    localparam int         SDIO_MODE_BIT = 7;
    localparam int         LSB_FIRST_BIT = 8;
    localparam int         AMPL_LSB      = 0;
    localparam int         AMPL_W        = 14;
    localparam int         RAMP_LSB      = 14;
    localparam int         RAMP_W        = 2;

    // Instruction byte layout
    localparam int         INSTR_RW_BIT  = 7;
    localparam int         INSTR_ADDR_W  = 5;

    // Storage shape
    localparam int         NUM_REGS      = 8;
    localparam int         REG_W         = 32;
    localparam logic [2:0] LAST_BIT      = 3'h7;
    localparam logic [2:0] BIT_RESET     = 3'h0;

    // Values after reset
    localparam logic [REG_W-1:0] REG_RESET = 32'h0000_0000;

    typedef enum logic [0:0] {
        SCP_INSTR = 1'b0,
        SCP_DATA  = 1'b1
    } scp_phase_e;

    // Bytes per register; unlisted addresses take one dummy byte
    function automatic logic [2:0] scp_reg_bytes(input logic [4:0] addr);
        logic [2:0] n;
        n = 3'h1;
        case (addr)
            5'h00:   n = 3'h4;
            5'h01:   n = 3'h3;
            5'h02:   n = 3'h2;
            5'h03:   n = 3'h4;
            5'h04:   n = 3'h4;
            5'h05:   n = 3'h2;
            default: n = 3'h1;
        endcase
        return n;
    endfunction

    function automatic logic scp_reg_present(input logic [4:0] addr);
        return scp_reg_bytes(addr) != 3'h1;
    endfunction

    // One serial bit into a byte in the selected order
    function automatic logic [7:0] scp_shift_in(input logic [7:0] sh,
                                                input logic       b,
                                                input logic       lsb);
        return lsb ? {b, sh[7:1]} : {sh[6:0], b};
    endfunction

endpackage

// [core/scp_port.sv]
`timescale 1ns/1ps
module scp_port (
    input  wire logic        sys_clk,
    input  wire logic        reset,
    input  wire logic        sclk,
    input  wire logic        chip_select_n,
    input  wire logic        sdio_in,
    input  wire logic        port_abort,
    output logic             sdio_out,
    output logic             sdio_oe,
    output logic             serial_data_out,
    output logic             serial_data_out_oe,
    output logic             lsb_first,
    output logic             separate_out_mode,
    output logic [13:0]      amplitude_scale_factor,
    output logic [1:0]       auto_ramp_rate_ctl
);

    typedef struct packed {
        scp_pkg::scp_phase_e                               phase;
        logic [2:0]                                        bit_cnt;
        logic [7:0]                                        shift;
        logic                                              rd;
        logic [4:0]                                        addr;
        logic [1:0]                                        byte_idx;
        logic [2:0]                                        left;
        logic [scp_pkg::REG_W-1:0]                         stage;
        logic                                              tx_bit;
        logic                                              sdio_oe;
        logic                                              sdo_oe;
        logic [scp_pkg::NUM_REGS-1:0][scp_pkg::REG_W-1:0] regs;
    } scp_state_s;

    scp_state_s s_q;
    scp_state_s s_d;

    scp_pins_if pins ();

    scp_pin_sync u_sync (
        .sys_clk       (sys_clk),
        .reset         (reset),
        .sclk          (sclk),
        .chip_select_n (chip_select_n),
        .sdio_in       (sdio_in),
        .port_abort    (port_abort),
        .pins          (pins.sync)
    );

    ////////////////////////////////////////////////////////////////////
    logic                        lsb;
    logic                        sep;
    logic [7:0]                  rx_byte;
    logic [7:0]                  tx_byte;
    logic [2:0]                  nbytes;
    logic                        active;
    logic [scp_pkg::REG_W-1:0]   new_stage;

    always_comb begin
        lsb = s_q.regs[0][scp_pkg::LSB_FIRST_BIT];
        sep = s_q.regs[0][scp_pkg::SDIO_MODE_BIT];
        // Frozen while deselected; resumes on the next edge
        active  = ~pins.sel_n & ~pins.abort;
        rx_byte = scp_pkg::scp_shift_in(s_q.shift, pins.data_in, lsb);
        nbytes  = scp_pkg::scp_reg_bytes(rx_byte[4:0]);
        tx_byte = s_q.stage[{s_q.byte_idx, 3'h0} +: 8];
        new_stage = s_q.stage;
        new_stage[{s_q.byte_idx, 3'h0} +: 8] = rx_byte;
    end

    always_comb begin
        s_d = s_q;
        if (pins.abort) begin
            // Registers survive; only the port machine restarts
            s_d.phase   = scp_pkg::SCP_INSTR;
            s_d.bit_cnt = scp_pkg::BIT_RESET;
        end else if (active && pins.sclk_rise) begin
            s_d.shift   = rx_byte;
            s_d.bit_cnt = s_q.bit_cnt + 3'h1;
            if (s_q.bit_cnt == scp_pkg::LAST_BIT) begin
                s_d.shift = 8'h00;
                if (s_q.phase == scp_pkg::SCP_INSTR) begin
                    s_d.rd    = rx_byte[scp_pkg::INSTR_RW_BIT];
                    s_d.addr  = rx_byte[scp_pkg::INSTR_ADDR_W-1:0];
                    s_d.left  = nbytes;
                    // Start byte follows the bit order
                    s_d.byte_idx = lsb ? 2'h0
                                       : 2'(nbytes - 3'h1);
                    s_d.stage = scp_pkg::scp_reg_present(rx_byte[4:0])
                              ? s_q.regs[rx_byte[2:0]]
                              : scp_pkg::REG_RESET;
                    s_d.phase = scp_pkg::SCP_DATA;
                end else begin
                    s_d.stage = new_stage;
                    if (s_q.left == 3'h1) begin
                        s_d.phase = scp_pkg::SCP_INSTR;
                        // Whole word commits at once, so order bits stay
                        // steady through their own write
                        if (!s_q.rd
                            && scp_pkg::scp_reg_present(s_q.addr)) begin
                            s_d.regs[s_q.addr[2:0]] = new_stage;
                        end
                    end else begin
                        s_d.left     = s_q.left - 3'h1;
                        s_d.byte_idx = lsb ? s_q.byte_idx + 2'h1
                                           : s_q.byte_idx - 2'h1;
                    end
                end
            end
        end else if (active && pins.sclk_fall && s_q.rd
                     && s_q.phase == scp_pkg::SCP_DATA) begin
            s_d.tx_bit = lsb ? tx_byte[s_q.bit_cnt]
                             : tx_byte[3'h7 - s_q.bit_cnt];
        end
        // Drive only in a read data phase with the chip selected
        s_d.sdio_oe = active && s_d.rd && s_d.phase == scp_pkg::SCP_DATA
                      && !sep && (pins.sclk_fall || s_q.sdio_oe);
        s_d.sdo_oe  = active && s_d.rd && s_d.phase == scp_pkg::SCP_DATA
                      && sep && (pins.sclk_fall || s_q.sdo_oe);
    end

    ////////////////////////////////////////////////////////////////////
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            s_q <= '{phase:    scp_pkg::SCP_INSTR,
                     bit_cnt:  scp_pkg::BIT_RESET,
                     shift:    8'h00,
                     rd:       1'b0,
                     addr:     5'h00,
                     byte_idx: 2'h0,
                     left:     3'h0,
                     stage:    scp_pkg::REG_RESET,
                     tx_bit:   1'b0,
                     sdio_oe:  1'b0,
                     sdo_oe:   1'b0,
                     regs:     {scp_pkg::NUM_REGS{scp_pkg::REG_RESET}}};
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    assign sdio_out               = s_q.tx_bit;
    assign sdio_oe                = s_q.sdio_oe;
    assign serial_data_out        = s_q.tx_bit;
    assign serial_data_out_oe     = s_q.sdo_oe;
    assign lsb_first              = s_q.regs[0][scp_pkg::LSB_FIRST_BIT];
    assign separate_out_mode      = s_q.regs[0][scp_pkg::SDIO_MODE_BIT];
    assign amplitude_scale_factor =
        s_q.regs[2][scp_pkg::AMPL_LSB +: scp_pkg::AMPL_W];
    assign auto_ramp_rate_ctl     =
        s_q.regs[2][scp_pkg::RAMP_LSB +: scp_pkg::RAMP_W];

endmodule

// [testbench/scp_host.sv]
`timescale 1ns/1ps
module scp_host (
    input  wire logic sys_clk,
    output logic      sclk,
    output logic      chip_select_n,
    output logic      sdio_in,
    output logic      port_abort,
    input  wire logic sdio_out,
    input  wire logic sdio_oe,
    input  wire logic serial_data_out,
    input  wire logic serial_data_out_oe
);
    // Which enables were seen high during data bits: {two-way, separate}
    logic [1:0] oe_seen;
    initial begin
        oe_seen = 2'h0;
        sclk = 1'b0;
        chip_select_n = 1'b1;
        sdio_in = 1'b0;
        port_abort = 1'b0;
    end
    task automatic wait_n(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    // Clock still moves while deselected; released data shows inverse
    task automatic xfer(input logic [7:0] ins, input int n,
                        input logic [31:0] wv, input logic lsb,
                        input int brk, input logic abrt,
                        output logic [31:0] rv);
        logic b;
        rv = 32'h0000_0000;
        oe_seen = 2'h0;
        chip_select_n = 1'b0;
        wait_n(4);
        for (int i = 0; i < 8 + n; i++) begin
            if (i == brk && abrt) begin
                port_abort = 1'b1;
                wait_n(8);
                sclk = 1'b0;
                port_abort = 1'b0;
                chip_select_n = 1'b1;
                sdio_in = ~sdio_in;
                wait_n(8);
                return;
            end
            if (i == brk) begin
                chip_select_n = 1'b1;
                sdio_in = ~sdio_in;
                repeat (2) begin
                    sclk = 1'b0;
                    wait_n(4);
                    sclk = 1'b1;
                    wait_n(4);
                end
                chip_select_n = 1'b0;
                wait_n(4);
            end
            b = (i < 8) ? (lsb ? ins[i] : ins[7-i])
                : (lsb ? wv[i-8] : wv[n-1-(i-8)]);
            sclk = 1'b0;
            sdio_in = b;
            wait_n(4);
            sclk = 1'b1;
            wait_n(2);
            if (i >= 8) begin
                // A pin nobody drives reads back inverted
                oe_seen = oe_seen | {sdio_oe, serial_data_out_oe};
                rv[lsb ? i-8 : n+7-i] = sdio_oe ? sdio_out
                    : serial_data_out_oe ? serial_data_out : ~sdio_out;
            end
            wait_n(2);
        end
        chip_select_n = 1'b1;
        sdio_in = ~b;
        wait_n(4);
        sclk = 1'b0;
        wait_n(8);
    endtask
endmodule

// [testbench/scp_port_monitor.sv]
`timescale 1ns/1ps
module scp_port_monitor (
    input wire logic        sys_clk,
    input wire logic        reset,
    input wire logic        sclk,
    input wire logic        chip_select_n,
    input wire logic        sdio_in,
    input wire logic        port_abort,
    input wire logic        sdio_out,
    input wire logic        sdio_oe,
    input wire logic        serial_data_out,
    input wire logic        serial_data_out_oe,
    input wire logic        lsb_first,
    input wire logic        separate_out_mode,
    input wire logic [13:0] amplitude_scale_factor,
    input wire logic [1:0]  auto_ramp_rate_ctl
);
    // Saturating ages; raw pins, so bounds allow for the sync delay
    logic [3:0] cs_cnt, ab_cnt, rise_cnt, fall_cnt;
    logic       sclk_q;
    function automatic logic [3:0] sat(input logic [3:0] c);
        return (c == 4'hf) ? c : c + 4'h1;
    endfunction
    always_ff @(posedge sys_clk) begin
        sclk_q <= sclk;
        if (reset) begin
            cs_cnt   <= 4'h0;
            ab_cnt   <= 4'h0;
            rise_cnt <= 4'hf;
            fall_cnt <= 4'hf;
        end else begin
            cs_cnt   <= chip_select_n ? sat(cs_cnt) : 4'h0;
            ab_cnt   <= port_abort ? sat(ab_cnt) : 4'h0;
            rise_cnt <= (sclk && !sclk_q) ? 4'h0 : sat(rise_cnt);
            fall_cnt <= (!sclk && sclk_q) ? 4'h0 : sat(fall_cnt);
        end
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    a_cs_quiet: assert property (
        cs_cnt > 4'h5 |-> !(sdio_oe || serial_data_out_oe))
        else $error("data pin driven while deselected");
    a_two_way_quiet: assert property (
        !separate_out_mode |-> !serial_data_out_oe)
        else $error("separate output driven in two-way mode");
    a_sep_route: assert property (separate_out_mode |-> !sdio_oe)
        else $error("two-way pin driven in separate mode");
    a_abort_quiet: assert property (
        ab_cnt > 4'h5 |-> !(sdio_oe || serial_data_out_oe))
        else $error("data pin driven during abort");
    a_abort_keeps: assert property (ab_cnt > 4'h3 |=>
        $stable(amplitude_scale_factor) && $stable(lsb_first)
        && $stable(auto_ramp_rate_ctl) && $stable(separate_out_mode))
        else $error("register changed during abort");
    a_write_on_rise: assert property (
        $changed(amplitude_scale_factor) || $changed(lsb_first)
        |-> rise_cnt < 4'h8) else $error("register change without rise");
    a_data_on_fall: assert property (
        sdio_oe && $past(sdio_oe) && $changed(sdio_out) |-> fall_cnt < 4'h8)
        else $error("read bit changed away from falling edge");
    a_sep_on_fall: assert property (
        $rose(serial_data_out_oe) |-> fall_cnt < 4'h8 && cs_cnt == 4'h0)
        else $error("separate output enabled away from falling edge");
    c_write: cover property ($changed(amplitude_scale_factor));
    c_read_two_way: cover property ($rose(sdio_oe));
    c_read_sep: cover property ($rose(serial_data_out_oe));
    c_abort: cover property (ab_cnt > 4'h5);
endmodule
bind scp_port scp_port_monitor u_scp_port_monitor (.sys_clk, .reset, .sclk,
    .chip_select_n, .sdio_in, .port_abort, .sdio_out, .sdio_oe,
    .serial_data_out, .serial_data_out_oe, .lsb_first, .separate_out_mode,
    .amplitude_scale_factor, .auto_ramp_rate_ctl);

// [testbench/tb.sv]
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin \
    n_mismatch++; $display("mismatch %s expected %h seen %h", nm, ex, got); \
    end end
module tb;
    logic        sys_clk, reset, sclk, chip_select_n, sdio_in, port_abort;
    logic        sdio_out, sdio_oe, serial_data_out, serial_data_out_oe;
    logic        lsb_first, separate_out_mode;
    logic [13:0] amplitude_scale_factor;
    logic [1:0]  auto_ramp_rate_ctl;
    logic [31:0] rv;
    int          n_mismatch = 0;
    int          checked = 0;
    scp_port u_scp_port (.sys_clk, .reset, .sclk, .chip_select_n, .sdio_in,
        .port_abort, .sdio_out, .sdio_oe, .serial_data_out,
        .serial_data_out_oe, .lsb_first, .separate_out_mode,
        .amplitude_scale_factor, .auto_ramp_rate_ctl);
    scp_host u_scp_host (.sys_clk, .sclk, .chip_select_n, .sdio_in,
        .port_abort, .sdio_out, .sdio_oe, .serial_data_out,
        .serial_data_out_oe);
    ////////////////////////////////////////////////////////////////////////
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic t_msb;
        u_scp_host.xfer(8'h62, 16, 32'h0000_8005, 1'b0, -1, 1'b0, rv);
        `CHK("asf", 14'h0005, amplitude_scale_factor)
        `CHK("ramp", 2'h2, auto_ramp_rate_ctl)
        u_scp_host.xfer(8'h82, 16, 32'h0000_0000, 1'b0, -1, 1'b0, rv);
        `CHK("rd msb", 16'h8005, rv[15:0])
        `CHK("oe two way", 2'h2, u_scp_host.oe_seen)
    endtask
    task automatic t_abort;
        u_scp_host.xfer(8'h02, 16, 32'h0000_1234, 1'b0, 12, 1'b1, rv);
        `CHK("asf abort", 14'h0005, amplitude_scale_factor)
        u_scp_host.xfer(8'h02, 16, 32'h0000_4321, 1'b0, -1, 1'b0, rv);
        `CHK("asf new", 14'h0321, amplitude_scale_factor)
        `CHK("ramp new", 2'h1, auto_ramp_rate_ctl)
    endtask
    task automatic t_suspend;
        u_scp_host.xfer(8'h02, 16, 32'h0000_00aa, 1'b0, 13, 1'b0, rv);
        `CHK("asf resume", 14'h00aa, amplitude_scale_factor)
    endtask
    task automatic t_sep;
        u_scp_host.xfer(8'h00, 32, 32'h0000_0080, 1'b0, -1, 1'b0, rv);
        `CHK("sep mode", 1'b1, separate_out_mode)
        u_scp_host.xfer(8'h82, 16, 32'h0000_0000, 1'b0, -1, 1'b0, rv);
        `CHK("rd sep", 16'h00aa, rv[15:0])
        `CHK("oe sep", 2'h1, u_scp_host.oe_seen)
        `CHK("oe idle", 1'b0, sdio_oe | serial_data_out_oe)
        u_scp_host.xfer(8'h87, 8, 32'h0000_0000, 1'b0, -1, 1'b0, rv);
        `CHK("rd dummy", 8'h00, rv[7:0])
    endtask
    task automatic t_lsb;
        u_scp_host.xfer(8'h00, 32, 32'h0000_0180, 1'b0, -1, 1'b0, rv);
        `CHK("lsb mode", 1'b1, lsb_first)
        u_scp_host.xfer(8'h02, 16, 32'h0000_e123, 1'b1, -1, 1'b0, rv);
        `CHK("asf lsb", 14'h2123, amplitude_scale_factor)
        `CHK("ramp lsb", 2'h3, auto_ramp_rate_ctl)
        u_scp_host.xfer(8'h82, 16, 32'h0000_0000, 1'b1, -1, 1'b0, rv);
        `CHK("rd lsb", 16'he123, rv[15:0])
        `CHK("oe lsb", 2'h1, u_scp_host.oe_seen)
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    initial begin
        repeat (30000) @(posedge sys_clk);
        n_mismatch++;
        print_verdict();
    end
    initial begin
        reset = 1'b1;
        repeat (3) @(negedge sys_clk);
        reset = 1'b0;
        repeat (4) @(negedge sys_clk);
        `CHK("lsb reset", 1'b0, lsb_first)
        `CHK("mode reset", 1'b0, separate_out_mode)
        t_msb();
        t_abort();
        t_suspend();
        t_sep();
        t_lsb();
        print_verdict();
    end
endmodule
